// ---- rtl/sbr_scoreboard.sv ----
// Scoreboard reservation: issue, designators, read flags, store and read.
//
// Contract
// - Busy, F, Q, then list update in order.
// - Load result and two entry designators.
// - Designators three bits, register within group.
// - Shift, increment groups decoded per instruction.
// - One reservation designator per register, 24.
// - Copy reserving unit code into Q.
// - Unreserved operand: Q zero, flag set.
// - Octal unit codes 00 to 17, 10 unused.
// - Fetch operands only with both flags set.
// - Hold issue while result register reserved.
// - Issue despite reserved entry operand, Q loaded.
// - List update from unit, group, number decodes.
// - Four-bit codes; index/address designators two bits.
// - Memory access reserves address and paired operand.
// - Matching release sets operand read flag.
// - Store granted only when path all clear.
// - Store grant clears busy and list entry.
// - Store grant wakes every matching waiting operand.
// - Go read needs both flags, clear path.
// - Several units may read same cycle.
module sbr_scoreboard #(
  parameter int unsigned UNITS = sbr_pkg::NUM_UNITS
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             issue_valid,
  input  wire logic [3:0]       issue_unit_code,
  input  wire logic [5:0]       opcode_field,
  input  wire logic [2:0]       issue_i,
  input  wire logic [2:0]       issue_j,
  input  wire logic [2:0]       issue_k,
  input  wire logic [UNITS-1:0] release_req,
  input  wire logic [UNITS-1:0] read_path_clear,
  input  wire logic             mem_done,
  input  wire logic [2:0]       mem_done_reg,
  output logic                  issue_taken_r,
  output logic                  issue_held_r,
  output logic      [UNITS-1:0] unit_busy_r,
  output logic      [UNITS-1:0] go_store_r,
  output logic      [2:0]       store_num_r,
  output logic      [1:0]       store_grp_r,
  output logic      [UNITS-1:0] go_read_r
);

  if (UNITS != sbr_pkg::NUM_UNITS) begin : g_bad_units
    $error("sbr_scoreboard: UNITS must match the unit code table");
  end

  // ---------------------------------------------------------------
  // Per-unit designators
  // ---------------------------------------------------------------
  logic [2:0]       fi_r  [UNITS];
  logic [2:0]       fj_r  [UNITS];
  logic [2:0]       fk_r  [UNITS];
  logic [1:0]       gi_r  [UNITS];
  logic [1:0]       gj_r  [UNITS];
  logic [1:0]       gk_r  [UNITS];
  logic [3:0]       qj_r  [UNITS];
  logic [3:0]       qk_r  [UNITS];
  logic [UNITS-1:0] rfj_r;
  logic [UNITS-1:0] rfk_r;
  logic [UNITS-1:0] read_done_r;
  logic [sbr_pkg::NUM_REGS-1:0] reserved_r;

  // Second-stage group decode for the instruction at issue.
  logic [1:0] dec_gi;
  logic [1:0] dec_gj;
  logic [1:0] dec_gk;
  always_comb begin
    dec_gi = sbr_pkg::GRP_OPERAND;
    dec_gj = sbr_pkg::GRP_OPERAND;
    dec_gk = sbr_pkg::GRP_OPERAND;
    if (issue_unit_code == sbr_pkg::CODE_SHIFT ||
        issue_unit_code == sbr_pkg::CODE_INCR1 ||
        issue_unit_code == sbr_pkg::CODE_INCR2) begin
      case (opcode_field[5:3])
        sbr_pkg::OPC_SHIFT_HI: dec_gj = sbr_pkg::GRP_INDEX;
        sbr_pkg::OPC_MEMORY: begin
          dec_gi = sbr_pkg::GRP_ADDRESS;
          dec_gj = sbr_pkg::GRP_ADDRESS;
          dec_gk = sbr_pkg::GRP_INDEX;
        end
        sbr_pkg::OPC_INDEX: begin
          dec_gi = sbr_pkg::GRP_INDEX;
          dec_gj = sbr_pkg::GRP_INDEX;
          dec_gk = sbr_pkg::GRP_INDEX;
        end
        sbr_pkg::OPC_OPERAND: dec_gk = sbr_pkg::GRP_INDEX;
        default: dec_gi = sbr_pkg::GRP_OPERAND;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Issue decision
  // ---------------------------------------------------------------
  logic [UNITS-1:0] sel;
  logic             is_branch;
  logic [4:0]       i_idx;
  logic [4:0]       pair_idx;
  logic             pair_en;
  logic             pair_want;
  logic [3:0]       pair_code;
  logic             unit_free;
  logic             issue_go;

  always_comb begin
    for (int s = 0; s < UNITS; s++) begin
      sel[s] = issue_unit_code == sbr_pkg::UNIT_CODE[s];
    end
  end

  assign is_branch = issue_unit_code == sbr_pkg::CODE_BRANCH;
  assign i_idx     = {dec_gi, issue_i};
  assign pair_idx  = {sbr_pkg::GRP_OPERAND, issue_i};
  assign unit_free = is_branch || |(sel & ~unit_busy_r);
  // A memory access to a nonzero address register also needs its twin free.
  assign pair_want = !is_branch && issue_i != 3'h0 &&
                     opcode_field[5:3] == sbr_pkg::OPC_MEMORY &&
                     dec_gi == sbr_pkg::GRP_ADDRESS;
  assign pair_en   = issue_go && pair_want;
  assign pair_code = (issue_i < sbr_pkg::MEM_WRITE_LO) ?
                     (sbr_pkg::CODE_MEMRD0 | 4'(issue_i)) : issue_unit_code;
  assign issue_go  = issue_valid && unit_free &&
                     (is_branch || !reserved_r[i_idx]) &&
                     !(pair_want && reserved_r[pair_idx]);

  // ---------------------------------------------------------------
  // Store grant: all clear test and one grant per cycle
  // ---------------------------------------------------------------
  logic [UNITS-1:0] all_clear;
  logic [UNITS-1:0] grant;
  logic             grant_any;
  logic [3:0]       grant_code;
  logic [2:0]       grant_num;
  logic [1:0]       grant_grp;

  always_comb begin
    for (int u = 0; u < UNITS; u++) begin
      all_clear[u] = 1'b1;
      for (int v = 0; v < UNITS; v++) begin
        if (v != u && unit_busy_r[v] && !read_done_r[v] &&
            ((rfj_r[v] && fj_r[v] == fi_r[u] && gj_r[v] == gi_r[u]) ||
             (rfk_r[v] && fk_r[v] == fi_r[u] && gk_r[v] == gi_r[u]))) begin
          all_clear[u] = 1'b0;
        end
      end
    end
    grant      = '0;
    grant_any  = 1'b0;
    grant_code = sbr_pkg::CODE_BRANCH;
    grant_num  = 3'h0;
    grant_grp  = sbr_pkg::GRP_OPERAND;
    for (int u = 0; u < UNITS; u++) begin
      if (!grant_any && release_req[u] && unit_busy_r[u] &&
          read_done_r[u] && all_clear[u]) begin
        grant[u]   = 1'b1;
        grant_any  = 1'b1;
        grant_code = sbr_pkg::UNIT_CODE[u];
        grant_num  = fi_r[u];
        grant_grp  = gi_r[u];
      end
    end
  end

  // ---------------------------------------------------------------
  // Reservation list and its busy shadow
  // ---------------------------------------------------------------
  logic [3:0] rd_j_code;
  logic [3:0] rd_k_code;
  logic [4:0] mem_idx;

  assign mem_idx = {sbr_pkg::GRP_OPERAND, mem_done_reg};
  sbr_resv_list u_list (
    .clk       (clk),
    .srst      (srst),
    .wr_en     (issue_go && !is_branch),
    .wr_idx    (i_idx),
    .wr_code   (issue_unit_code),
    .pair_en   (pair_en),
    .pair_idx  (pair_idx),
    .pair_code (pair_code),
    .clr_en    (grant_any),
    .clr_idx   ({grant_grp, grant_num}),
    .clr2_en   (mem_done),
    .clr2_idx  (mem_idx),
    .rd_j_idx  ({dec_gj, issue_j}),
    .rd_k_idx  ({dec_gk, issue_k}),
    .rd_j_code (rd_j_code),
    .rd_k_code (rd_k_code)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      reserved_r <= '0;
    end else begin
      for (int e = 0; e < sbr_pkg::NUM_REGS; e++) begin
        if (issue_go && !is_branch && i_idx == 5'(e)) begin
          reserved_r[e] <= 1'b1;
        end else if (pair_en && pair_idx == 5'(e)) begin
          reserved_r[e] <= 1'b1;
        end else if ((grant_any && {grant_grp, grant_num} == 5'(e)) ||
                     (mem_done && mem_idx == 5'(e))) begin
          reserved_r[e] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Q load stage, one cycle after issue
  // ---------------------------------------------------------------
  logic [UNITS-1:0] qload_r;
  logic             rel_prev_r;
  logic [3:0]       rel_prev_code_r;
  logic             mem_prev_r;
  logic [3:0]       mem_prev_code_r;
  logic [3:0]       mem_code;

  assign mem_code = sbr_pkg::CODE_MEMRD0 | 4'(mem_done_reg);
  always_ff @(posedge clk) begin
    if (srst) begin
      qload_r         <= '0;
      rel_prev_r      <= 1'b0;
      rel_prev_code_r <= sbr_pkg::CODE_BRANCH;
      mem_prev_r      <= 1'b0;
      mem_prev_code_r <= sbr_pkg::CODE_BRANCH;
    end else begin
      qload_r         <= issue_go ? sel : '0;
      rel_prev_r      <= grant_any;
      rel_prev_code_r <= grant_code;
      mem_prev_r      <= mem_done && mem_done_reg < sbr_pkg::MEM_WRITE_LO;
      mem_prev_code_r <= mem_code;
    end
  end

  // Wake test: a release in this cycle, or one that the list read missed.
  function automatic logic wakes(input logic [3:0] q, input logic fresh);
    logic hit;
    hit = (grant_any && q == grant_code) ||
          (mem_done && q == mem_code && q != sbr_pkg::CODE_UNUSED &&
           mem_done_reg < sbr_pkg::MEM_WRITE_LO);
    if (fresh) begin
      hit = hit || q == sbr_pkg::CODE_BRANCH ||
            (rel_prev_r && q == rel_prev_code_r) ||
            (mem_prev_r && q == mem_prev_code_r);
    end
    return hit;
  endfunction : wakes

  // ---------------------------------------------------------------
  // Unit designators, busy, read flags and go read
  // ---------------------------------------------------------------
  logic [UNITS-1:0] read_go;
  assign read_go = unit_busy_r & ~read_done_r & rfj_r & rfk_r &
                   read_path_clear;

  for (genvar u = 0; u < UNITS; u++) begin : g_unit
    always_ff @(posedge clk) begin
      if (srst) begin
        unit_busy_r[u] <= 1'b0;
        fi_r[u]        <= 3'h0;
        fj_r[u]        <= 3'h0;
        fk_r[u]        <= 3'h0;
        gi_r[u]        <= sbr_pkg::GRP_OPERAND;
        gj_r[u]        <= sbr_pkg::GRP_OPERAND;
        gk_r[u]        <= sbr_pkg::GRP_OPERAND;
      end else if (issue_go && sel[u]) begin
        unit_busy_r[u] <= 1'b1;
        fi_r[u]        <= issue_i;
        fj_r[u]        <= issue_j;
        fk_r[u]        <= issue_k;
        gi_r[u]        <= dec_gi;
        gj_r[u]        <= dec_gj;
        gk_r[u]        <= dec_gk;
      end else if (grant[u]) begin
        unit_busy_r[u] <= 1'b0;
      end
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        qj_r[u]        <= 4'h0;
        qk_r[u]        <= 4'h0;
        rfj_r[u]       <= 1'b0;
        rfk_r[u]       <= 1'b0;
        read_done_r[u] <= 1'b0;
      end else if (issue_go && sel[u]) begin
        rfj_r[u]       <= 1'b0;
        rfk_r[u]       <= 1'b0;
        read_done_r[u] <= 1'b0;
      end else if (qload_r[u]) begin
        qj_r[u]  <= rd_j_code;
        qk_r[u]  <= rd_k_code;
        rfj_r[u] <= wakes(rd_j_code, 1'b1);
        rfk_r[u] <= wakes(rd_k_code, 1'b1);
      end else if (read_go[u]) begin
        rfj_r[u]       <= 1'b0;
        rfk_r[u]       <= 1'b0;
        read_done_r[u] <= 1'b1;
      end else if (unit_busy_r[u] && !read_done_r[u]) begin
        if (!rfj_r[u] && wakes(qj_r[u], 1'b0)) begin
          rfj_r[u] <= 1'b1;
        end
        if (!rfk_r[u] && wakes(qk_r[u], 1'b0)) begin
          rfk_r[u] <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      issue_taken_r <= 1'b0;
      issue_held_r  <= 1'b0;
      go_store_r    <= '0;
      store_num_r   <= 3'h0;
      store_grp_r   <= sbr_pkg::GRP_OPERAND;
      go_read_r     <= '0;
    end else begin
      issue_taken_r <= issue_go;
      issue_held_r  <= issue_valid && !issue_go;
      go_store_r    <= grant;
      store_num_r   <= grant_num;
      store_grp_r   <= grant_grp;
      go_read_r     <= read_go;
    end
  end

endmodule : sbr_scoreboard

// ---- include/sbr_pkg.sv ----
// Package holding the codes, groups and sizes of the scoreboard reservation.
package sbr_pkg;

  // ---------------------------------------------------------------
  // Register groups and sizes
  // ---------------------------------------------------------------
  localparam int unsigned NUM_UNITS   = 9;
  localparam int unsigned NUM_REGS    = 24;
  localparam int unsigned REG_BITS    = 3;
  localparam int unsigned GRP_BITS    = 2;
  localparam int unsigned CODE_BITS   = 4;
  localparam int unsigned IDX_BITS    = 5;
  localparam int unsigned OP_BITS     = 6;
  localparam int unsigned NARROW_BITS = 2;
  localparam int unsigned GRP_SIZE    = 8;

  localparam logic [1:0] GRP_OPERAND = 2'h0;
  localparam logic [1:0] GRP_INDEX   = 2'h1;
  localparam logic [1:0] GRP_ADDRESS = 2'h2;

  // ---------------------------------------------------------------
  // Unit codes, octal 00 to 17, with octal 10 unused
  // ---------------------------------------------------------------
  localparam logic [3:0] CODE_BRANCH  = 4'h0;
  localparam logic [3:0] CODE_INCR1   = 4'h1;
  localparam logic [3:0] CODE_INCR2   = 4'h2;
  localparam logic [3:0] CODE_SHIFT   = 4'h3;
  localparam logic [3:0] CODE_BOOLEAN = 4'h4;
  localparam logic [3:0] CODE_DIVIDE  = 4'h5;
  localparam logic [3:0] CODE_MULT1   = 4'h6;
  localparam logic [3:0] CODE_MULT2   = 4'h7;
  localparam logic [3:0] CODE_UNUSED  = 4'h8;
  localparam logic [3:0] CODE_MEMRD0  = 4'h8;
  localparam logic [3:0] CODE_LONGADD = 4'hE;
  localparam logic [3:0] CODE_ADD     = 4'hF;

  // Unit slot order; slot s carries code UNIT_CODE[s].
  localparam logic [3:0] UNIT_CODE [NUM_UNITS] = '{
    4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hE, 4'hF
  };

  // ---------------------------------------------------------------
  // Opcode classes seen by the second-stage group decode, and the first memory-write register
  // ---------------------------------------------------------------
  localparam logic [2:0] OPC_SHIFT_HI = 3'h2;
  localparam logic [2:0] OPC_MEMORY   = 3'h5;
  localparam logic [2:0] OPC_INDEX    = 3'h6;
  localparam logic [2:0] OPC_OPERAND  = 3'h7;
  localparam logic [2:0] MEM_WRITE_LO = 3'h6;

endpackage : sbr_pkg

// ---- rtl/sbr_resv_list.sv ----
// Reservation list: one designator per operating register, registered reads.
module sbr_resv_list (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       wr_en,
  input  wire logic [4:0] wr_idx,
  input  wire logic [3:0] wr_code,
  input  wire logic       pair_en,
  input  wire logic [4:0] pair_idx,
  input  wire logic [3:0] pair_code,
  input  wire logic       clr_en,
  input  wire logic [4:0] clr_idx,
  input  wire logic       clr2_en,
  input  wire logic [4:0] clr2_idx,
  input  wire logic [4:0] rd_j_idx,
  input  wire logic [4:0] rd_k_idx,
  output logic      [3:0] rd_j_code,
  output logic      [3:0] rd_k_code
);

  logic [3:0] entry [sbr_pkg::NUM_REGS];

  // ---------------------------------------------------------------
  // Entries: operand group four bits, index and address groups two
  // ---------------------------------------------------------------
  for (genvar e = 0; e < sbr_pkg::NUM_REGS; e++) begin : g_entry
    localparam int unsigned W = (e < sbr_pkg::GRP_SIZE) ?
                                sbr_pkg::CODE_BITS : sbr_pkg::NARROW_BITS;
    logic [W-1:0] store_r;
    always_ff @(posedge clk) begin
      if (srst) begin
        store_r <= '0;
      end else if (wr_en && wr_idx == 5'(e)) begin
        store_r <= wr_code[W-1:0];
      end else if (pair_en && pair_idx == 5'(e)) begin
        store_r <= pair_code[W-1:0];
      end else if ((clr_en && clr_idx == 5'(e)) ||
                   (clr2_en && clr2_idx == 5'(e))) begin
        store_r <= '0;
      end
    end
    assign entry[e] = 4'(store_r);
  end

  // ---------------------------------------------------------------
  // Read ports see the value before this edge's update
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_j_code <= 4'h0;
      rd_k_code <= 4'h0;
    end else begin
      rd_j_code <= entry[rd_j_idx];
      rd_k_code <= entry[rd_k_idx];
    end
  end

endmodule : sbr_resv_list

// ---- tb/sbr_scoreboard_assertions.sv ----
// Concurrent checks on the ports of the scoreboard reservation block.
module sbr_scoreboard_assertions #(
  parameter int unsigned UNITS = sbr_pkg::NUM_UNITS
) (
  input wire logic             clk,
  input wire logic             srst,
  input wire logic             issue_valid,
  input wire logic [3:0]       issue_unit_code,
  input wire logic [5:0]       opcode_field,
  input wire logic [2:0]       issue_i,
  input wire logic [2:0]       issue_j,
  input wire logic [2:0]       issue_k,
  input wire logic [UNITS-1:0] release_req,
  input wire logic [UNITS-1:0] read_path_clear,
  input wire logic             mem_done,
  input wire logic [2:0]       mem_done_reg,
  input wire logic             issue_taken_r,
  input wire logic             issue_held_r,
  input wire logic [UNITS-1:0] unit_busy_r,
  input wire logic [UNITS-1:0] go_store_r,
  input wire logic [2:0]       store_num_r,
  input wire logic [1:0]       store_grp_r,
  input wire logic [UNITS-1:0] go_read_r
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Slot of the offered unit, and its copy one cycle later
  // ---------------------------------------------------------------
  logic [UNITS-1:0] slot_oh;
  logic [UNITS-1:0] slot_oh_r;

  always_comb begin
    slot_oh = '0;
    for (int s = 0; s < UNITS; s++) begin
      if (sbr_pkg::UNIT_CODE[s] == issue_unit_code) slot_oh[s] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    slot_oh_r <= slot_oh;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_accept;
    issue_valid ##1 issue_taken_r;
  endsequence

  a_reset_clears: assert property (disable iff (1'b0) srst |=>
    (unit_busy_r == '0 && go_store_r == '0 && go_read_r == '0))
    else $error("outputs not cleared by reset");
  a_one_answer: assert property (
    issue_valid |=> issue_taken_r != issue_held_r)
    else $error("issue answer missing or doubled");
  a_accept_busy: assert property (
    s_accept |-> (unit_busy_r & slot_oh_r) == slot_oh_r)
    else $error("accepted unit not busy");
  a_busy_refused: assert property (
    issue_valid && (unit_busy_r & slot_oh) != '0 |=> issue_held_r)
    else $error("busy unit accepted");
  a_store_onehot: assert property ($onehot0(go_store_r))
    else $error("several store grants");
  a_store_cause: assert property (
    (go_store_r & ~($past(release_req) & $past(unit_busy_r))) == '0)
    else $error("store without request");
  a_busy_drop: assert property (
    ($past(unit_busy_r) & ~unit_busy_r) == go_store_r)
    else $error("busy drop differs from store grant");
  a_store_pulse: assert property (
    (go_store_r & $past(go_store_r)) == '0)
    else $error("store grant longer than a cycle");
  a_read_cause: assert property (
    (go_read_r & ~($past(read_path_clear) & $past(unit_busy_r))) == '0)
    else $error("read without clear path");
endmodule : sbr_scoreboard_assertions

bind sbr_scoreboard sbr_scoreboard_assertions #(.UNITS(UNITS)) i_chk (
  .clk(clk), .srst(srst), .issue_valid(issue_valid),
  .issue_unit_code(issue_unit_code), .opcode_field(opcode_field),
  .issue_i(issue_i), .issue_j(issue_j), .issue_k(issue_k),
  .release_req(release_req), .read_path_clear(read_path_clear),
  .mem_done(mem_done), .mem_done_reg(mem_done_reg),
  .issue_taken_r(issue_taken_r), .issue_held_r(issue_held_r),
  .unit_busy_r(unit_busy_r), .go_store_r(go_store_r),
  .store_num_r(store_num_r), .store_grp_r(store_grp_r),
  .go_read_r(go_read_r)
);

// ---- tb/sbr_unit_model.sv ----
// Behavioural model of the functional units facing the scoreboard.
module sbr_unit_model #(
  parameter int unsigned UNITS = sbr_pkg::NUM_UNITS
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             slow,
  input  wire logic [UNITS-1:0] go_read_r,
  input  wire logic [UNITS-1:0] go_store_r,
  output logic      [UNITS-1:0] release_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Compute delay after reading, then ask to release until granted
  // ---------------------------------------------------------------
  int unsigned cnt_r [UNITS];

  always_ff @(posedge clk) begin
    for (int u = 0; u < UNITS; u++) begin
      if (srst) begin
        cnt_r[u]       <= 0;
        release_req[u] <= 1'b0;
      end else if (go_read_r[u]) begin
        cnt_r[u] <= slow ? 12 : 1;
      end else if (cnt_r[u] > 1) begin
        cnt_r[u] <= cnt_r[u] - 1;
      end else if (cnt_r[u] == 1) begin
        cnt_r[u]       <= 0;
        release_req[u] <= 1'b1;
      end else if (go_store_r[u]) begin
        release_req[u] <= 1'b0;
      end
    end
  end
endmodule : sbr_unit_model

// ---- tb/testbench.sv ----
// Self-checking testbench of the scoreboard reservation block.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned U = sbr_pkg::NUM_UNITS;

  logic         clk, srst, issue_valid, mem_done, slow;
  logic [3:0]   issue_unit_code;
  logic [5:0]   opcode_field;
  logic [2:0]   issue_i, issue_j, issue_k, mem_done_reg, store_num_r, r;
  logic [1:0]   store_grp_r;
  logic [U-1:0] release_req, read_path_clear, go_store_r, go_read_r;
  logic [U-1:0] unit_busy_r;
  logic         issue_taken_r, issue_held_r;
  logic [1:0]   exp_q [$];
  logic [4:0]   exp_dst [U];
  int           st_t [U];
  int           rd_t [U];
  int           cyc, t_mem, mismatches, n_checks;
  logic [31:0]  seed;
  logic [3:0]   codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                               4'h6, 4'h7, 4'hE, 4'hF};

  sbr_scoreboard #(.UNITS(U)) i_dut (
    .clk(clk), .srst(srst), .issue_valid(issue_valid),
    .issue_unit_code(issue_unit_code), .opcode_field(opcode_field),
    .issue_i(issue_i), .issue_j(issue_j), .issue_k(issue_k),
    .release_req(release_req), .read_path_clear(read_path_clear),
    .mem_done(mem_done), .mem_done_reg(mem_done_reg),
    .issue_taken_r(issue_taken_r), .issue_held_r(issue_held_r),
    .unit_busy_r(unit_busy_r), .go_store_r(go_store_r),
    .store_num_r(store_num_r), .store_grp_r(store_grp_r),
    .go_read_r(go_read_r));

  sbr_unit_model #(.UNITS(U)) i_units (
    .clk(clk), .srst(srst), .slow(slow), .go_read_r(go_read_r),
    .go_store_r(go_store_r), .release_req(release_req));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      mismatches++;
      $display("BAD t=%0t %s", $time, msg);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  task automatic issue(input logic [3:0] c, input logic [5:0] op,
                       input logic [2:0] i, input logic [2:0] j,
                       input logic [2:0] k, input logic [1:0] g,
                       input logic ok);
    @(posedge clk);
    issue_valid     <= 1'b1;
    issue_unit_code <= c;
    opcode_field    <= op;
    issue_i         <= i;
    issue_j         <= j;
    issue_k         <= k;
    exp_q.push_back({ok, ~ok});
    if (ok && c != 4'h0) exp_dst[(c < 4'h8) ? c - 1 : c - 7] = {g, i};
    @(posedge clk);
    issue_valid <= 1'b0;
  endtask : issue

  task automatic drain();
    for (int n = 0; n < 400; n++) begin
      @(posedge clk);
      if (unit_busy_r === '0 && release_req === '0) break;
    end
    chk(unit_busy_r === '0, "units still busy");
    repeat (2) @(posedge clk);
  endtask : drain

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Output watcher: answers against noted expectations, event times
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    read_path_clear <= U'($random(seed));
    if (!srst && (issue_taken_r | issue_held_r)) begin
      if (exp_q.size() == 0) chk(1'b0, "unexpected issue answer");
      else chk(exp_q.pop_front() === {issue_taken_r, issue_held_r},
               "issue answer");
    end
    for (int u = 0; u < U; u++) begin
      if (go_store_r[u] === 1'b1) begin
        st_t[u] = cyc;
        chk({store_grp_r, store_num_r} === exp_dst[u], "store dest");
      end
      if (go_read_r[u] === 1'b1) rd_t[u] = cyc;
    end
    if (cyc > 20000) begin
      chk(1'b0, "timeout");
      end_sim();
    end
  end

  initial begin
    seed = 32'hA39D7ECB;
    {srst, slow} = 2'h3;
    {issue_valid, mem_done} = 2'h0;
    {issue_unit_code, opcode_field} = 10'h000;
    {issue_i, issue_j, issue_k, mem_done_reg} = 12'h000;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    issue(4'hF, 6'h00, 3'h0, 3'h2, 3'h3, 2'h0, 1'b1);
    issue(4'h6, 6'h00, 3'h0, 3'h4, 3'h5, 2'h0, 1'b0);
    issue(4'hF, 6'h00, 3'h5, 3'h1, 3'h1, 2'h0, 1'b0);
    drain();
    st_t = '{default: 0};
    rd_t = '{default: 0};
    r = 3'($unsigned($random(seed)) % 5 + 1);
    issue(4'h6, 6'h00, r, 3'h0, 3'h0, 2'h0, 1'b1);
    issue(4'hF, 6'h00, 3'h0, r, 3'h0, 2'h0, 1'b1);
    issue(4'h4, 6'h00, 3'h7, r, r, 2'h0, 1'b1);
    drain();
    chk(st_t[5] > 0 && rd_t[8] > st_t[5], "add read early");
    chk(rd_t[3] > st_t[5], "boolean read early");
    slow <= 1'b0;
    issue(4'h1, 6'h28, 3'h1, 3'h2, 3'h3, 2'h2, 1'b1);
    drain();
    issue(4'hF, 6'h00, 3'h1, 3'h2, 3'h3, 2'h0, 1'b0);
    issue(4'hF, 6'h00, 3'h4, 3'h1, 3'h2, 2'h0, 1'b1);
    repeat (20) @(posedge clk);
    mem_done     <= 1'b1;
    mem_done_reg <= 3'h1;
    t_mem = cyc;
    @(posedge clk);
    mem_done <= 1'b0;
    drain();
    chk(rd_t[8] > t_mem, "read before memory data");
    issue(4'hF, 6'h00, 3'h1, 3'h2, 3'h3, 2'h0, 1'b1);
    drain();
    for (int n = 0; n < 10; n++) begin
      issue(codes[n], 6'h00, 3'(n), 3'($random(seed)), 3'($random(seed)),
            2'h0, 1'b1);
      drain();
    end
    slow <= 1'b1;
    issue(4'h2, 6'h30, 3'h5, 3'h1, 3'h2, 2'h1, 1'b1);
    issue(4'h3, 6'h10, 3'h6, 3'h5, 3'h0, 2'h0, 1'b1);
    issue(4'h1, 6'h38, 3'h7, 3'h0, 3'h5, 2'h0, 1'b1);
    drain();
    chk(rd_t[2] > st_t[1] && rd_t[0] > st_t[1], "B operand early");
    issue(4'h5, 6'h00, 3'h2, 3'h3, 3'h4, 2'h0, 1'b1);
    repeat (3) @(posedge clk);
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(unit_busy_r === '0 && go_read_r === '0, "reset state");
    issue(4'h5, 6'h00, 3'h2, 3'h3, 3'h4, 2'h0, 1'b1);
    drain();
    chk(exp_q.size() == 0, "missing issue answers");
    end_sim();
  end
endmodule : testbench
